// [aes_pkg.sv]
// Constants, field layouts and carrier types of the analog enable sequencer.
// Assumes a single 100 MHz system clock and a word-indexed register port.
package aes_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BANDGAP_SETTLE_NS = 2000;
   localparam int MULT_SETTLE_NS = 6000;
   localparam int THERMAL_SETTLE_NS = 2000;
   localparam int AOUT_MIN_PERIOD_NS = 1000;
   localparam int BANDGAP_SETTLE_CYC = (BANDGAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MULT_SETTLE_CYC = (MULT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int THERMAL_SETTLE_CYC = (THERMAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AOUT_GAP_CYC = (AOUT_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Converter timing in converter clock ticks
   localparam logic [4:0] MIN_SAMPLE_CYC = 5'h05;
   localparam logic [4:0] SAMPLE_EXTRA_CYC = 5'h02;
   localparam logic [4:0] CONVERT_CYC = 5'h0c;

   // Register indices
   localparam logic [7:0] ADDR_POWER = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CLOCK = 8'h02;
   localparam logic [7:0] ADDR_CONV = 8'h03;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_TRIM = 8'h05;
   localparam logic [7:0] ADDR_AMP = 8'h06;
   localparam logic [7:0] ADDR_COMP = 8'h07;
   localparam logic [7:0] ADDR_AOUT = 8'h08;
   localparam logic [3:0] PAGE_CHAN = 4'h1;
   localparam logic [3:0] PAGE_RESULT = 4'h2;

   // Power register bits
   localparam int PWR_FAST_OSC_PD = 0;
   localparam int PWR_BANDGAP_PD = 1;
   localparam int PWR_MULT_ON = 2;
   localparam int PWR_CONV_ON = 3;
   localparam int PWR_AMP_ON = 4;
   localparam int PWR_COMP0_ON = 5;
   localparam int PWR_COMP1_ON = 6;
   localparam int PWR_THERMAL_ON = 7;
   localparam int PWR_AOUT_ON = 8;
   localparam logic [8:0] POWER_RESET = 9'h000;

   // Status register bits
   localparam int ST_BANDGAP_READY = 0;
   localparam int ST_MULT_READY = 1;
   localparam int ST_CONV_BUSY = 2;
   localparam int ST_THERMAL_READY = 3;
   localparam int ST_SCAN_DONE = 4;

   // Clock register fields
   localparam int CLK_RATIO_LSB = 0;
   localparam int CLK_DIV_LSB = 4;
   localparam logic [3:0] MULT_RATIO_MAX = 4'hc;
   localparam logic [3:0] MULT_RATIO_RESET = 4'hc;
   localparam logic [3:0] CONV_DIV_RESET = 4'h2;

   // Converter register fields
   localparam int CONV_MODE_LSB = 0;
   localparam int CONV_LAST_LSB = 2;
   localparam int CONV_WINDOW_LSB = 6;
   localparam int CONV_GAIN = 10;
   localparam int CONV_TMASK_LSB = 11;
   localparam int CONV_PRESET_LSB = 15;
   localparam logic [3:0] WINDOW_RESET = 4'h3;
   localparam logic [7:0] PRESET_RESET = 8'h01;

   // Command bits
   localparam int CMD_SW_TRIGGER = 0;
   localparam int CMD_STOP = 1;

   localparam logic [4:0] TRIM_RESET = 5'h10;
   localparam int AMP_ROUTE_LSB = 2;
   localparam int COMP1_LSB = 7;
   localparam int AOUT_ROUTE = 8;

   typedef enum logic [1:0] {
      MODE_SINGLE_ONE,
      MODE_CONTINUOUS_ONE,
      MODE_SINGLE_SCAN,
      MODE_CONTINUOUS_SCAN
   } aes_mode_type;

   typedef struct packed {
      logic core_regulator_on;
      logic slow_osc_on;
      logic fast_osc_power_down;
      logic bandgap_power_down;
      logic multiplier_power_on;
      logic converter_on;
      logic amp_power_on;
      logic [1:0] comparator_power_on;
      logic thermal_sensor_power_on;
      logic analog_out_power_on;
   } aes_power_type;

   typedef struct packed {
      logic [3:0] multiplier_ratio;
      logic [3:0] converter_clk_div;
   } aes_clock_type;

   typedef struct packed {
      logic comparator_fast_select;
      logic comparator_hysteresis_select;
      logic [2:0] comparator_pos_source;
      logic [1:0] comparator_neg_source;
   } aes_comp_type;
endpackage

// [aes_conv.sv]
// Converter timing engine: sampling phase then fixed conversion phase.
// Assumes tick is a one-cycle converter clock pulse from the same clock.
module aes_conv (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic tick,
   input wire logic start,
   input wire logic abort,
   input wire logic [4:0] sample_cycles,
   output logic busy,
   output logic sampling,
   output logic done
);
   import aes_pkg::*;

   typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_CONVERT} aes_conv_state_type;
   typedef struct packed {
      aes_conv_state_type state;
      logic [4:0] count;
      logic [4:0] sample_len;
      logic done;
   } aes_conv_reg_type;

   aes_conv_reg_type st_reg;
   aes_conv_reg_type st_next;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      unique case (st_reg.state)
         CONV_IDLE: begin
            if (start) begin
               st_next.state = CONV_SAMPLE;
               st_next.count = 5'h00;
               // Never fewer than the minimum sampling span (RULE12)
               st_next.sample_len = (sample_cycles < MIN_SAMPLE_CYC) ? MIN_SAMPLE_CYC : sample_cycles;
            end
         end
         CONV_SAMPLE: begin
            if (tick) begin
               if (st_reg.count == st_reg.sample_len - 5'h01) begin
                  st_next.state = CONV_CONVERT;
                  st_next.count = 5'h00;
               end else begin
                  st_next.count = st_reg.count + 5'h01;
               end
            end
         end
         CONV_CONVERT: begin
            if (tick) begin
               if (st_reg.count == CONVERT_CYC - 5'h01) begin // RULE12
                  st_next.state = CONV_IDLE;
                  st_next.done = 1'b1;
               end else begin
                  st_next.count = st_reg.count + 5'h01;
               end
            end
         end
      endcase
      if (abort) begin
         st_next.state = CONV_IDLE;
         st_next.done = 1'b0;
      end
      if (srst) begin
         st_next.state = CONV_IDLE;
         st_next.count = 5'h00;
         st_next.sample_len = MIN_SAMPLE_CYC;
         st_next.done = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   assign busy = (st_reg.state != CONV_IDLE);
   assign sampling = (st_reg.state == CONV_SAMPLE);
   assign done = st_reg.done;
endmodule // aes_conv

// [aes_sequencer.sv]
// Analog enable sequencer: power enables, settling status, converter control.
// Assumes a register master on sys_clk; pin inputs are asynchronous.
//
// Notes on behaviour
// (RULE1) Digital reset while core supply is low
// (RULE2) Core regulator always on, trim only
// (RULE3) Slow oscillator runs, cannot be stopped
// (RULE4) Fast oscillator runs unless power-down set
// (RULE5) Software enables reference before fast oscillator
// (RULE6) Multiplier off at reset, software enables
// (RULE7) Software waits 6us before using multiplier
// (RULE8) Multiplied clock at most 48MHz
// (RULE9) Reference on at reset, settles 2us
// (RULE10) Software enables reference before analog users
// (RULE11) Converter off; software prepares clocks first
// (RULE12) Conversion: 5 sample plus 12 convert cycles
// (RULE13) Software programs sample window at least 3
// (RULE14) Four single/continuous channel and scan modes
// (RULE15) Sixteen per-channel scan register sets
// (RULE16) Start by software or counted timer triggers
// (RULE17) Gain select: unity or two-thirds
// (RULE18) Amplifiers off at reset, enable bit
// (RULE19) Comparator 3-bit positive, 2-bit negative source
// (RULE20) Comparators off at reset, per-unit enables
// (RULE21) Thermal sensor off, settles 2us
// (RULE22) Output converter off, updates at most 1MHz
module aes_sequencer (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic core_supply_low,
   input wire logic [3:0] timer_trigger,
   input wire logic [11:0] converter_data,
   output logic digital_reset,
   output aes_pkg::aes_power_type power,
   output aes_pkg::aes_clock_type clocks,
   output logic [4:0] core_regulator_trim,
   output logic converter_gain_select,
   output logic [3:0] converter_channel,
   output logic converter_sampling,
   output logic [1:0] amp_feedback_ratio,
   output logic [1:0] amp_output_route,
   output aes_pkg::aes_comp_type comp0,
   output aes_pkg::aes_comp_type comp1,
   output logic [7:0] analog_out_value,
   output logic converter_output_route
);
   import aes_pkg::*;

   typedef struct packed {
      logic core_low_s1;
      logic core_low_s2;
      logic digital_reset;
      logic [3:0] trig_s1;
      logic [3:0] trig_s2;
      logic [3:0] trig_prev;
      logic [11:0] data_s1;
      logic [11:0] data_s2;
      logic [8:0] power;
      logic [4:0] trim;
      logic [3:0] mult_ratio;
      logic [3:0] conv_div;
      logic [1:0] mode;
      logic [3:0] scan_last;
      logic [3:0] window;
      logic gain;
      logic [3:0] trig_mask;
      logic [7:0] trig_preset;
      logic [7:0] trig_count;
      logic [1:0] amp_ratio;
      logic [1:0] amp_route;
      logic [13:0] comp;
      logic [7:0] aout_pending;
      logic [7:0] aout_value;
      logic aout_dirty;
      logic aout_route;
      logic [6:0] aout_gap;
      logic [9:0] bg_cnt;
      logic [9:0] mult_cnt;
      logic [9:0] therm_cnt;
      logic bg_ready;
      logic mult_ready;
      logic therm_ready;
      logic [15:0][3:0] chan;
      logic [15:0][11:0] result;
      logic [3:0] scan_idx;
      logic running;
      logic start;
      logic scan_done;
      logic [3:0] div_cnt;
      logic tick;
      logic [31:0] rdata;
   } aes_state_type;

   aes_state_type st_reg;
   aes_state_type st_next;
   logic conv_busy;
   logic conv_sampling;
   logic conv_done;
   logic [3:0] trig_edges;
   logic trig_fire;
   logic sw_trigger;
   logic stop_cmd;

   // Settling counter: ready once enabled for the given number of cycles
   function automatic logic [10:0] settle(input logic on, input logic [9:0] cnt, input logic [9:0] lim);
      logic [9:0] c;
      logic r;
      c = cnt;
      r = 1'b0;
      if (!on) begin
         c = 10'h000;
      end else if (cnt >= lim) begin
         r = 1'b1;
      end else begin
         c = cnt + 10'h001;
      end
      return {r, c};
   endfunction

   aes_conv u_conv (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick(st_reg.tick),
      .start(st_reg.start),
      .abort(!st_reg.running),
      .sample_cycles({1'b0, st_reg.window} + SAMPLE_EXTRA_CYC),
      .busy(conv_busy),
      .sampling(conv_sampling),
      .done(conv_done)
   );

   assign sw_trigger = reg_write && (reg_addr == ADDR_CMD) && reg_wdata[CMD_SW_TRIGGER];
   assign stop_cmd = reg_write && (reg_addr == ADDR_CMD) && reg_wdata[CMD_STOP];
   assign trig_edges = st_reg.trig_s2 & ~st_reg.trig_prev & st_reg.trig_mask;
   assign trig_fire = (|trig_edges) && ({1'b0, st_reg.trig_count} + 9'h001 >= {1'b0, st_reg.trig_preset});

   always_comb begin
      st_next = st_reg;
      st_next.start = 1'b0;
      st_next.tick = 1'b0;
      st_next.rdata = 32'h0000_0000;
      // Pin synchronisers
      st_next.core_low_s1 = core_supply_low;
      st_next.core_low_s2 = st_reg.core_low_s1;
      st_next.digital_reset = st_reg.core_low_s2; // RULE1
      st_next.trig_s1 = timer_trigger;
      st_next.trig_s2 = st_reg.trig_s1;
      st_next.trig_prev = st_reg.trig_s2;
      st_next.data_s1 = converter_data;
      st_next.data_s2 = st_reg.data_s1;

      // Settling status for reference, multiplier and thermal sensor
      {st_next.bg_ready, st_next.bg_cnt} =
         settle(!st_reg.power[PWR_BANDGAP_PD], st_reg.bg_cnt, 10'(BANDGAP_SETTLE_CYC)); // RULE9
      {st_next.mult_ready, st_next.mult_cnt} =
         settle(st_reg.power[PWR_MULT_ON], st_reg.mult_cnt, 10'(MULT_SETTLE_CYC));
      {st_next.therm_ready, st_next.therm_cnt} =
         settle(st_reg.power[PWR_THERMAL_ON], st_reg.therm_cnt, 10'(THERMAL_SETTLE_CYC));

      // Converter clock tick from the divided system clock
      if (st_reg.div_cnt + 4'h1 >= st_reg.conv_div) begin
         st_next.div_cnt = 4'h0;
         st_next.tick = 1'b1;
      end else begin
         st_next.div_cnt = st_reg.div_cnt + 4'h1;
      end

      // Counted timer triggers
      if (|trig_edges) begin
         st_next.trig_count = trig_fire ? 8'h00 : st_reg.trig_count + 8'h01; // RULE16
      end

      // Register writes
      if (reg_write) begin
         unique case (reg_addr)
            ADDR_POWER: st_next.power = reg_wdata[8:0]; // RULE4 RULE6 RULE18 RULE20 RULE22
            ADDR_CLOCK: begin
               st_next.mult_ratio = (reg_wdata[CLK_RATIO_LSB +: 4] > MULT_RATIO_MAX) ?
                  MULT_RATIO_MAX : reg_wdata[CLK_RATIO_LSB +: 4]; // RULE8
               st_next.conv_div = reg_wdata[CLK_DIV_LSB +: 4];
            end
            ADDR_CONV: begin
               st_next.mode = reg_wdata[CONV_MODE_LSB +: 2];
               st_next.scan_last = reg_wdata[CONV_LAST_LSB +: 4];
               st_next.window = reg_wdata[CONV_WINDOW_LSB +: 4];
               st_next.gain = reg_wdata[CONV_GAIN]; // RULE17
               st_next.trig_mask = reg_wdata[CONV_TMASK_LSB +: 4];
               st_next.trig_preset = reg_wdata[CONV_PRESET_LSB +: 8];
            end
            ADDR_TRIM: st_next.trim = reg_wdata[4:0]; // RULE2
            ADDR_AMP: begin
               st_next.amp_ratio = reg_wdata[1:0];
               st_next.amp_route = reg_wdata[AMP_ROUTE_LSB +: 2];
            end
            ADDR_COMP: st_next.comp = reg_wdata[13:0]; // RULE19
            ADDR_AOUT: begin
               st_next.aout_pending = reg_wdata[7:0];
               st_next.aout_dirty = 1'b1;
               st_next.aout_route = reg_wdata[AOUT_ROUTE];
            end
            ADDR_STATUS: begin
               if (reg_wdata[ST_SCAN_DONE]) begin
                  st_next.scan_done = 1'b0;
               end
            end
            default: begin
               if (reg_addr[7:4] == PAGE_CHAN) begin
                  st_next.chan[reg_addr[3:0]] = reg_wdata[3:0]; // RULE15
               end
            end
         endcase
      end

      // Output converter update spacing
      if (st_reg.aout_gap != 7'h00) begin
         st_next.aout_gap = st_reg.aout_gap - 7'h01;
      end else if (st_reg.aout_dirty && !(reg_write && reg_addr == ADDR_AOUT)) begin
         st_next.aout_value = st_reg.aout_pending;
         st_next.aout_dirty = 1'b0;
         st_next.aout_gap = 7'(AOUT_GAP_CYC - 1); // RULE22
      end

      // Conversion sequencing
      if (conv_done) begin
         st_next.result[st_reg.scan_idx] = st_reg.data_s2;
         if ((st_reg.mode[1]) && (st_reg.scan_idx != st_reg.scan_last)) begin
            st_next.scan_idx = st_reg.scan_idx + 4'h1; // RULE14
            st_next.start = 1'b1;
         end else if (st_reg.mode == MODE_CONTINUOUS_ONE || st_reg.mode == MODE_CONTINUOUS_SCAN) begin
            st_next.scan_idx = 4'h0; // RULE14
            st_next.start = 1'b1;
         end else begin
            st_next.running = 1'b0;
         end
         st_next.scan_done = 1'b1;
      end else if (!st_reg.running && st_reg.power[PWR_CONV_ON] && (sw_trigger || trig_fire)) begin
         st_next.running = 1'b1; // RULE16
         st_next.scan_idx = 4'h0;
         st_next.start = 1'b1;
      end
      if (stop_cmd || !st_reg.power[PWR_CONV_ON]) begin
         st_next.running = 1'b0; // RULE11
         st_next.start = 1'b0;
      end

      // Register reads, answered in the next cycle
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_POWER: st_next.rdata = {23'h000000, st_reg.power};
            ADDR_STATUS: st_next.rdata = {27'h0000000, st_reg.scan_done, st_reg.therm_ready,
               conv_busy, st_reg.mult_ready, st_reg.bg_ready};
            ADDR_CLOCK: st_next.rdata = {24'h000000, st_reg.conv_div, st_reg.mult_ratio};
            ADDR_CONV: st_next.rdata = {9'h000, st_reg.trig_preset, st_reg.trig_mask, st_reg.gain,
               st_reg.window, st_reg.scan_last, st_reg.mode};
            ADDR_TRIM: st_next.rdata = {27'h0000000, st_reg.trim};
            ADDR_AMP: st_next.rdata = {28'h0000000, st_reg.amp_route, st_reg.amp_ratio};
            ADDR_COMP: st_next.rdata = {18'h00000, st_reg.comp};
            ADDR_AOUT: st_next.rdata = {23'h000000, st_reg.aout_route, st_reg.aout_value};
            default: begin
               if (reg_addr[7:4] == PAGE_CHAN) begin
                  st_next.rdata = {28'h0000000, st_reg.chan[reg_addr[3:0]]};
               end else if (reg_addr[7:4] == PAGE_RESULT) begin
                  st_next.rdata = {20'h00000, st_reg.result[reg_addr[3:0]]};
               end
            end
         endcase
      end

      if (srst) begin
         st_next = '0;
         st_next.digital_reset = 1'b1;
         st_next.power = POWER_RESET; // RULE4 RULE6 RULE9 RULE18 RULE20 RULE21 RULE22
         st_next.trim = TRIM_RESET;
         st_next.mult_ratio = MULT_RATIO_RESET;
         st_next.conv_div = CONV_DIV_RESET;
         st_next.window = WINDOW_RESET;
         st_next.trig_preset = PRESET_RESET;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   assign reg_rdata = st_reg.rdata;
   assign digital_reset = st_reg.digital_reset;
   assign power.core_regulator_on = 1'b1; // RULE2
   assign power.slow_osc_on = 1'b1; // RULE3
   assign power.fast_osc_power_down = st_reg.power[PWR_FAST_OSC_PD]; // RULE4
   assign power.bandgap_power_down = st_reg.power[PWR_BANDGAP_PD]; // RULE9
   assign power.multiplier_power_on = st_reg.power[PWR_MULT_ON]; // RULE6
   assign power.converter_on = st_reg.power[PWR_CONV_ON];
   assign power.amp_power_on = st_reg.power[PWR_AMP_ON]; // RULE18
   assign power.comparator_power_on = {st_reg.power[PWR_COMP1_ON], st_reg.power[PWR_COMP0_ON]}; // RULE20
   assign power.thermal_sensor_power_on = st_reg.power[PWR_THERMAL_ON]; // RULE21
   assign power.analog_out_power_on = st_reg.power[PWR_AOUT_ON]; // RULE22
   assign clocks.multiplier_ratio = st_reg.mult_ratio;
   assign clocks.converter_clk_div = st_reg.conv_div;
   assign core_regulator_trim = st_reg.trim;
   assign converter_gain_select = st_reg.gain;
   assign converter_channel = st_reg.chan[st_reg.scan_idx];
   assign converter_sampling = conv_sampling;
   assign amp_feedback_ratio = st_reg.amp_ratio;
   assign amp_output_route = st_reg.amp_route;
   assign comp0 = st_reg.comp[6:0];
   assign comp1 = st_reg.comp[COMP1_LSB +: 7];
   assign analog_out_value = st_reg.aout_value;
   assign converter_output_route = st_reg.aout_route;
endmodule // aes_sequencer

// [aes_sequencer_checker.sv]
// Port-level checks of the analog enable sequencer.
// Assumes one clock sys_clk and the synchronous active-high reset srst.
module aes_sequencer_checker (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic core_supply_low,
   input wire logic digital_reset,
   input wire aes_pkg::aes_power_type power,
   input wire aes_pkg::aes_clock_type clocks,
   input wire logic [4:0] core_regulator_trim,
   input wire logic converter_gain_select,
   input wire logic converter_sampling,
   input wire aes_pkg::aes_comp_type comp0,
   input wire aes_pkg::aes_comp_type comp1,
   input wire logic [7:0] analog_out_value
);
   import aes_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   logic [8:0] pwr_bits;
   logic [7:0] aout_q;
   logic [7:0] gap_cnt;
   // Power enables in register bit order
   assign pwr_bits = {power.analog_out_power_on, power.thermal_sensor_power_on, power.comparator_power_on,
      power.amp_power_on, power.converter_on, power.multiplier_power_on, power.bandgap_power_down,
      power.fast_osc_power_down};
   // Cycles since the output converter value last changed
   always_ff @(posedge sys_clk) begin
      aout_q <= analog_out_value;
      if (srst) gap_cnt <= 8'hff;
      else if (analog_out_value != aout_q) gap_cnt <= 8'h01;
      else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
   end
   sequence s_write(logic [7:0] a);
      reg_write && reg_addr == a;
   endsequence
   a_supply_low_reset: assert property (core_supply_low [*4] |-> digital_reset)
      else $error("digital reset missing while core supply low");
   a_supply_ok_run: assert property (!core_supply_low [*4] |-> !digital_reset)
      else $error("digital reset held while core supply good");
   a_always_running: assert property (power.core_regulator_on && power.slow_osc_on)
      else $error("core regulator or slow oscillator stopped");
   a_reset_values: assert property ($fell(srst) |-> pwr_bits == 9'h000 && core_regulator_trim == TRIM_RESET
      && clocks == {MULT_RATIO_RESET, CONV_DIV_RESET})
      else $error("wrong values after reset");
   a_ratio_limit: assert property (clocks.multiplier_ratio <= MULT_RATIO_MAX)
      else $error("multiplier ratio above limit");
   a_power_write: assert property (s_write(ADDR_POWER) |=> pwr_bits == $past(reg_wdata[8:0]))
      else $error("power enables do not follow write");
   a_comp_write: assert property (s_write(ADDR_COMP) |=> comp0 == $past(reg_wdata[6:0]) && comp1 == $past(reg_wdata[13:7]))
      else $error("comparator settings do not follow write");
   a_gain_write: assert property (s_write(ADDR_CONV) |=> converter_gain_select == $past(reg_wdata[CONV_GAIN]))
      else $error("gain select does not follow write");
   a_sample_min: assert property ($rose(converter_sampling) |-> converter_sampling [*5])
      else $error("sampling phase too short");
   a_read_quiet: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside read answer cycle");
   a_aout_spacing: assert property (analog_out_value != aout_q |-> gap_cnt >= AOUT_GAP_CYC)
      else $error("output converter updated too soon");
endmodule // aes_sequencer_checker

bind aes_sequencer aes_sequencer_checker aes_sequencer_checker_inst (.*);

// [test_aes_sequencer.sv]
// Self-checking bench of the analog enable sequencer through its register port.
// Assumes the checker file is compiled alongside and binds itself.
module test_aes_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import aes_pkg::*;
   logic sys_clk, srst, reg_write, reg_read, core_supply_low, digital_reset, converter_gain_select;
   logic converter_sampling, converter_output_route, samp_q;
   logic [7:0] reg_addr, analog_out_value;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] timer_trigger, converter_channel;
   logic [11:0] converter_data;
   logic [4:0] core_regulator_trim;
   logic [1:0] amp_feedback_ratio, amp_output_route;
   aes_power_type power;
   aes_clock_type clocks;
   aes_comp_type comp0, comp1;
   logic [8:0] pwr_bits;
   int fail_count = 0, n_tests = 0, rises = 0, run = 0, last_run = 0, base;
   aes_sequencer aes_sequencer_inst (.*);
   assign pwr_bits = {power.analog_out_power_on, power.thermal_sensor_power_on, power.comparator_power_on,
      power.amp_power_on, power.converter_on, power.multiplier_power_on, power.bandgap_power_down,
      power.fast_osc_power_down};
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Count sampling phases and measure the last one
   always @(posedge sys_clk) begin
      samp_q <= converter_sampling;
      if (converter_sampling === 1'b1 && samp_q !== 1'b1) rises <= rises + 1;
      if (converter_sampling === 1'b1) run <= run + 1;
      else begin
         if (run != 0) last_run <= run;
         run <= 0;
      end
   end
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      cyc(1);
      reg_write <= 1'b0;
      cyc(1);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      reg_addr <= a;
      reg_read <= 1'b1;
      cyc(1);
      reg_read <= 1'b0;
      cyc(1);
      check(n, e, reg_rdata);
   endtask
   task automatic pulse(input int t);
      timer_trigger <= 4'h1 << t;
      cyc(4);
      timer_trigger <= 4'h0;
      cyc(40);
   endtask
   initial begin
      cyc(20000);
      fail_count++;
      results();
   end
   initial begin
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      core_supply_low = 1'b0;
      timer_trigger = 4'h0;
      converter_data = 12'habc;
      cyc(16);
      srst <= 1'b0;
      cyc(2);
      check("power", 32'h600, power);
      check("clocks", 32'hc2, clocks);
      check("trim", 32'h10, core_regulator_trim);
      rchk(ADDR_CONV, 32'h80c0, "conv");
      wr(8'h0f, 32'hffff);
      rchk(8'h0f, 32'h0, "unmapped");
      core_supply_low <= 1'b1;
      cyc(6);
      check("dreset", 32'h1, digital_reset);
      core_supply_low <= 1'b0;
      cyc(6);
      check("dreset", 32'h0, digital_reset);
      for (int i = 0; i < 9; i++) begin
         wr(ADDR_POWER, 32'h1 << i);
         check("power_bits", 32'h1 << i, pwr_bits);
         rchk(ADDR_POWER, 32'h1 << i, "power_reg");
      end
      wr(ADDR_POWER, 32'h3);
      rchk(ADDR_STATUS, 32'h0, "status_off");
      wr(ADDR_POWER, 32'h84);
      cyc(150);
      rchk(ADDR_STATUS, 32'h0, "status_early");
      cyc(100);
      rchk(ADDR_STATUS, 32'h9, "status_ref");
      cyc(400);
      rchk(ADDR_STATUS, 32'hb, "status_all");
      wr(ADDR_CLOCK, 32'h1f);
      check("ratio", 32'hc, clocks.multiplier_ratio);
      wr(ADDR_CLOCK, 32'h17);
      check("ratio", 32'h7, clocks.multiplier_ratio);
      wr(ADDR_CLOCK, 32'h1c);
      wr(ADDR_POWER, 32'h8c);
      wr(8'h10, 32'h5);
      wr(8'h11, 32'h9);
      for (int w = 2; w < 8; w += 2) begin
         wr(ADDR_CONV, (w << 6) | 32'h8400);
         wr(ADDR_CMD, 32'h1);
         cyc(60);
         check("sample_len", (w + 2 > 5) ? w + 2 : 5, last_run);
         check("gain", 32'h1, converter_gain_select);
         check("channel", 32'h5, converter_channel);
         rchk(8'h20, 32'habc, "result");
         rchk(ADDR_STATUS, 32'h1b, "status_done");
         wr(ADDR_STATUS, 32'h10);
      end
      rchk(ADDR_STATUS, 32'hb, "status_clear");
      for (int m = 0; m < 4; m++) begin
         base = rises;
         wr(ADDR_CONV, m | 32'h80c4);
         wr(ADDR_CMD, 32'h1);
         cyc(120);
         // In the continuous modes, stop only in the conversion phase so no sampling phase is cut short
         while (m[0] && !(samp_q === 1'b1 && converter_sampling === 1'b0)) cyc(1);
         wr(ADDR_CMD, 32'h2);
         cyc(40);
         check("mode_runs", m[0] ? 32'h1 : m / 2 + 1, m[0] ? 32'(rises - base >= 4) : rises - base);
         rchk(ADDR_STATUS, 32'h1b, "mode_stop");
         wr(ADDR_STATUS, 32'h10);
      end
      rchk(8'h21, 32'habc, "result_one");
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_CONV, (32'h1 << (11 + t)) | 32'h100c0);
         base = rises;
         pulse(t);
         check("trig_first", 32'h0, rises - base);
         pulse(t);
         check("trig_second", 32'h1, rises - base);
      end
      wr(ADDR_COMP, 32'h2a55);
      check("comp0", 32'h55, comp0);
      check("comp1", 32'h54, comp1);
      wr(ADDR_AMP, 32'he);
      check("amp", 32'he, {amp_output_route, amp_feedback_ratio});
      wr(ADDR_TRIM, 32'h1f);
      check("trim", 32'h1f, core_regulator_trim);
      wr(ADDR_AOUT, 32'h1a5);
      cyc(2);
      check("aout", 32'h1a5, {converter_output_route, analog_out_value});
      wr(ADDR_AOUT, 32'h13c);
      cyc(2);
      check("aout_hold", 32'ha5, analog_out_value);
      cyc(110);
      check("aout_next", 32'h3c, analog_out_value);
      results();
   end
endmodule // test_aes_sequencer
